// [verilog/oscp_top.v]
// Functional notes
// RQ1 - read-only current source, eight encodings
// RQ2 - writable next source, same encoding
// RQ3 - software avoids direct pll-to-pll switch
// RQ4 - source lock blocks switching when monitor off
// RQ5 - pin select lock rejects pin writes
// RQ6 - pll lock status bit read-only
// RQ7 - hardware sets fail flag, software clears
// RQ8 - secondary oscillator enable bit
// RQ9 - switch request cleared when complete
// RQ10 - control writes need unlock sequence
// RQ11 - registers reset only on power-on
// RQ12 - interrupt clears reduction enable if recover
// RQ13 - core reduction divides by power two
// RQ14 - reduction disabled forces ratio 1:1
// RQ15 - rc postscale, code seven divides 256
// RQ16 - vco post divider 2/4/8, 10 reserved
// RQ17 - prescale divides by value plus two
// RQ18 - feedback multiplier value plus two
// RQ19 - six bit signed rc trim
// RQ20 - unimplemented bits read zero
// RQ21 - next source loaded from config at reset
// RQ22 - redundant switch request aborted
// RQ23 - wait ten new clocks then change over
// RQ24 - fail flag stays until written zero
`timescale 1ns/1ps
`include "oscp_defines.vh"
module oscp_top
(
  // clock, power-on reset, clock enable
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_clk_en,
  // wishbone classic slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // configuration settings
  input wire [2:0] i_cfg_src,
  input wire [1:0] i_cfg_monitor,
  // oscillator side events, from other domains
  input wire i_pll_locked,
  input wire i_clk_fail,
  input wire i_new_clk_tick,
  input wire i_irq,
  // outputs to the clock tree
  output reg [2:0] o_cur_src,
  output reg o_sec_osc_en,
  output reg o_pin_lock,
  output reg [7:0] o_core_div,
  output reg [8:0] o_rc_div,
  output reg [3:0] o_vco_div,
  output reg [5:0] o_pre_div,
  output reg [9:0] o_fb_mult,
  output reg [5:0] o_rc_trim
);
  // ***********************************************************
  // input synchronisers
  // ***********************************************************
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg tick_d1_q;
  wire pll_lk = sync2_q[0];
  wire fail_s = sync2_q[1];
  wire irq_s = sync2_q[3];
  // edge of the new-clock tick, only from second stage
  wire tick_rise = sync2_q[2] & ~tick_d1_q;
  // two flops on every foreign input
  always @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      tick_d1_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      sync1_q <= {i_irq, i_new_clk_tick, i_clk_fail, i_pll_locked};
      sync2_q <= sync1_q;
      tick_d1_q <= sync2_q[2];
    end
  end
  // ***********************************************************
  // registers
  // ***********************************************************
  reg [2:0] cur_q;
  reg [2:0] nxt_q;
  reg src_lock_q;
  reg pin_lock_q;
  reg fail_q;
  reg sec_en_q;
  reg req_q;
  reg [15:0] div_q;
  reg [8:0] fbd_q;
  reg [5:0] tun_q;
  reg [1:0] key_q;
  reg [3:0] wait_q;
  reg cfg_ld_q;
  // ***********************************************************
  // bus decode
  // ***********************************************************
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  wire wr = wb_req & i_wb_we & i_clk_en;
  wire lo_b = i_wb_sel[0];
  wire hi_b = i_wb_sel[1];
  wire wr_key = wr && (i_wb_adr == `OSCP_OFS_KEY);
  // RQ10 unlock gating
  wire wr_osc = wr && (i_wb_adr == {4'h0, `OSCP_OFS_OSC_CTRL}) &&
                key_q[1];
  wire wr_div = wr && (i_wb_adr == {4'h0, `OSCP_OFS_CLK_DIV});
  wire wr_fbd = wr && (i_wb_adr == {4'h0, `OSCP_OFS_PLL_FBD});
  wire wr_tun = wr && (i_wb_adr == {4'h0, `OSCP_OFS_RC_TUNE});
  // RQ4 lock only applies with switching on, monitor off
  // the lock value written alongside the request decides, so that
  // one write can both release the lock and start a switch
  wire sw_blocked = i_wb_dat[`OSCP_SRC_LOCK_BIT] &&
                    (i_cfg_monitor == `OSCP_MON_SWITCH_ONLY);
  // unlock key state: two keys in a row arm one write
  always @(posedge i_ref_clk)
  begin
    if (!i_nrst)
      key_q <= 2'h0;
    else if (wr_key && key_q == 2'h0 &&
             i_wb_dat[15:0] == `OSCP_KEY1)
      key_q <= 2'h1;
    else if (wr_key && key_q == 2'h1 &&
             i_wb_dat[15:0] == `OSCP_KEY2)
      key_q <= 2'h2;
    else if (wr)
      key_q <= 2'h0;
  end
  // ***********************************************************
  // oscillator control and switch sequence
  // ***********************************************************
  always @(posedge i_ref_clk)
  begin
    // RQ11 only reset input is power-on
    if (!i_nrst)
    begin
      cur_q <= `OSCP_SRC_FRC;
      nxt_q <= `OSCP_SRC_FRC;
      src_lock_q <= 1'b0;
      pin_lock_q <= 1'b0;
      fail_q <= 1'b0;
      sec_en_q <= 1'b0;
      req_q <= 1'b0;
      wait_q <= 4'h0;
      cfg_ld_q <= 1'b1;
    end
    else if (i_clk_en)
    begin
      // RQ21 strap captured after release
      if (cfg_ld_q)
      begin
        cur_q <= i_cfg_src;
        nxt_q <= i_cfg_src;
        cfg_ld_q <= 1'b0;
      end
      if (wr_osc && hi_b)
        // RQ2 next source write
        nxt_q <= i_wb_dat[`OSCP_NXT_LSB+2:`OSCP_NXT_LSB];
      if (wr_osc && lo_b)
      begin
        src_lock_q <= i_wb_dat[`OSCP_SRC_LOCK_BIT];
        pin_lock_q <= i_wb_dat[`OSCP_PIN_LOCK_BIT];
        // RQ8 secondary enable
        sec_en_q <= i_wb_dat[`OSCP_SEC_EN_BIT];
        if (i_wb_dat[`OSCP_SW_REQ_BIT] && !sw_blocked && !req_q)
        begin
          req_q <= 1'b1;
          wait_q <= 4'h0;
        end
      end
      // RQ7 fail flag, RQ24 set wins over clear, write one keeps
      if (fail_s)
        fail_q <= 1'b1;
      else if (wr_osc && lo_b && !i_wb_dat[`OSCP_FAIL_BIT])
        fail_q <= 1'b0;
      if (req_q && !cfg_ld_q)
      begin
        // RQ22 redundant switch aborted
        if (nxt_q == cur_q)
          req_q <= 1'b0;
        // RQ3 switch sequence waits for pll lock on pll targets
        else if ((nxt_q == `OSCP_SRC_PRI_PLL ||
                  nxt_q == `OSCP_SRC_FRC_PLL) && !pll_lk)
          wait_q <= 4'h0;
        else if (tick_rise)
        begin
          // RQ23 ten new clock ticks then change over
          if (wait_q == `OSCP_SWITCH_WAIT - 4'h1)
          begin
            cur_q <= nxt_q;
            // RQ9 report completion
            req_q <= 1'b0;
          end
          else
            wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
  // ***********************************************************
  // divisor, feedback and trim registers
  // ***********************************************************
  always @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      div_q <= `OSCP_CLK_DIV_RST;
      fbd_q <= `OSCP_PLL_FBD_RST;
      tun_q <= `OSCP_RC_TUNE_RST;
    end
    else if (i_clk_en)
    begin
      // RQ20 unimplemented bits dropped on write
      if (wr_div && lo_b)
        div_q[7:0] <= {i_wb_dat[7:6], 1'b0, i_wb_dat[4:0]};
      if (wr_div && hi_b)
        div_q[15:8] <= i_wb_dat[15:8];
      // RQ12 interrupt recovers full speed, after any write
      if (div_q[15] && irq_s)
        div_q[11] <= 1'b0;
      if (wr_fbd && lo_b)
        fbd_q[7:0] <= i_wb_dat[7:0];
      if (wr_fbd && hi_b)
        fbd_q[8] <= i_wb_dat[8];
      // RQ19 signed trim stored
      if (wr_tun && lo_b)
        tun_q <= i_wb_dat[5:0];
    end
  end
  // ***********************************************************
  // read mux and ack
  // ***********************************************************
  reg [31:0] rd_d;
  always @*
  begin
    rd_d = 32'h0;
    // RQ1 current source, RQ6 pll lock, RQ20 zeros elsewhere
    if (i_wb_adr == {4'h0, `OSCP_OFS_OSC_CTRL})
      rd_d = {16'h0, 1'b0, cur_q, 1'b0, nxt_q, src_lock_q, pin_lock_q,
              pll_lk, 1'b0, fail_q, 1'b0, sec_en_q, req_q};
    else if (i_wb_adr == {4'h0, `OSCP_OFS_CLK_DIV})
      rd_d = {16'h0, div_q};
    else if (i_wb_adr == {4'h0, `OSCP_OFS_PLL_FBD})
      rd_d = {23'h0, fbd_q};
    else if (i_wb_adr == {4'h0, `OSCP_OFS_RC_TUNE})
      rd_d = {26'h0, tun_q};
  end
  // one wait state free answer: ack one cycle after request
  always @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end
    else if (i_clk_en)
    begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we)
        o_wb_dat <= rd_d;
    end
  end
  // ***********************************************************
  // decoded clock tree controls
  // ***********************************************************
  always @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      o_cur_src <= 3'h0;
      o_sec_osc_en <= 1'b0;
      o_pin_lock <= 1'b0;
      o_core_div <= 8'h1;
      o_rc_div <= 9'h1;
      o_vco_div <= 4'h2;
      o_pre_div <= 6'h2;
      o_fb_mult <= 10'h2;
      o_rc_trim <= 6'h0;
    end
    else if (i_clk_en)
    begin
      o_cur_src <= cur_q;
      o_sec_osc_en <= sec_en_q;
      // RQ5 pin select write blocker
      o_pin_lock <= pin_lock_q;
      // RQ13 power of two, RQ14 forced 1:1 when disabled
      o_core_div <= div_q[11] ? (8'h1 << div_q[14:12]) : 8'h1;
      // RQ15 postscale, seven means 256
      o_rc_div <= (div_q[10:8] == 3'h7) ? 9'h100 :
                  (9'h1 << div_q[10:8]);
      // RQ16 reserved code kept at last legal divide
      if (div_q[7:6] != 2'h2)
        o_vco_div <= (div_q[7:6] == 2'h3) ? 4'h8 :
                     (div_q[6] ? 4'h4 : 4'h2);
      // RQ17 prescale plus two
      o_pre_div <= {1'b0, div_q[4:0]} + 6'h2;
      // RQ18 multiplier plus two
      o_fb_mult <= {1'b0, fbd_q} + 10'h2;
      o_rc_trim <= tun_q;
    end
  end
endmodule // oscp_top

// [verilog/oscp_defines.vh]
`ifndef OSCP_DEFINES_VH
`define OSCP_DEFINES_VH
// ***********************************************************
// register byte offsets
// ***********************************************************
`define OSCP_OFS_OSC_CTRL 4'h0
`define OSCP_OFS_CLK_DIV 4'h4
`define OSCP_OFS_PLL_FBD 4'h8
`define OSCP_OFS_RC_TUNE 4'hc
// ***********************************************************
// unlock keys, written to the key register before each oscillator control write
// ***********************************************************
`define OSCP_OFS_KEY 8'h10
`define OSCP_KEY1 16'h0046
`define OSCP_KEY2 16'h0057
// ***********************************************************
// oscillator control field positions
// ***********************************************************
`define OSCP_CUR_LSB 12
`define OSCP_NXT_LSB 8
`define OSCP_SRC_LOCK_BIT 7
`define OSCP_PIN_LOCK_BIT 6
`define OSCP_PLL_LOCK_BIT 5
`define OSCP_FAIL_BIT 3
`define OSCP_SEC_EN_BIT 1
`define OSCP_SW_REQ_BIT 0
// ***********************************************************
// reset values, masks, source and monitor encodings
// ***********************************************************
`define OSCP_CLK_DIV_RST 16'h3040
`define OSCP_CLK_DIV_MASK 16'hffdf
`define OSCP_PLL_FBD_RST 9'h030
`define OSCP_RC_TUNE_RST 6'h00
`define OSCP_SRC_FRC 3'h0
`define OSCP_SRC_FRC_PLL 3'h1
`define OSCP_SRC_PRI_PLL 3'h3
`define OSCP_MON_SWITCH_ONLY 2'h1
// ***********************************************************
// timing: new clock cycles before changeover
// ***********************************************************
`define OSCP_SWITCH_WAIT 4'ha
`endif

// [test/oscp_osc_model.sv]
`timescale 1ns/1ps
// ***********************************************************
// oscillators and pll seen from the block
// ***********************************************************
module oscp_osc_model
(
  // controls from the bench
  input wire i_pll_on,
  input wire i_fail,
  // levels towards the block
  output reg o_pll_locked = 1'b0,
  output reg o_clk_fail = 1'b0,
  output reg o_tick = 1'b0
);
  parameter LOCK_NS = 300;
  // new clock, free running, unrelated to the ref clock
  always #11 o_tick = ~o_tick;
  // lock comes only after start-up, drops at once when off
  always @(i_pll_on)
  begin
    o_pll_locked = 1'b0;
    if (i_pll_on)
      o_pll_locked = #LOCK_NS i_pll_on;
  end
  always @* o_clk_fail = i_fail;
endmodule // oscp_osc_model

// [test/oscp_top_sva.sv]
`timescale 1ns/1ps
module oscp_top_sva
(
  // clock and bus
  input wire i_ref_clk,
  input wire i_nrst,
  input wire i_clk_en,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  // decoded clock tree values
  input wire [7:0] o_core_div,
  input wire [8:0] o_rc_div,
  input wire [3:0] o_vco_div,
  input wire [5:0] o_pre_div,
  input wire [9:0] o_fb_mult
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // a request the slave takes this edge
  wire tk = i_wb_cyc && i_wb_stb && !o_wb_ack && i_clk_en;
  property p_ack; tk |=> o_wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("no ack");
  property p_pulse; o_wb_ack |=> !o_wb_ack; endproperty
  a_pulse: assert property (p_pulse) else $error("long ack");
  // reset values first, decoded defaults a little later
  property p_rst;
    $rose(i_nrst) |-> o_pre_div == 6'h02 ##[1:3]
      (o_fb_mult == 10'd50 && o_core_div == 8'h01 && o_vco_div == 4'h4);
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_core; $onehot(o_core_div); endproperty
  a_core: assert property (p_core) else $error("core div");
  property p_rc; $onehot(o_rc_div) && !o_rc_div[7]; endproperty
  a_rc: assert property (p_rc) else $error("rc div");
  property p_vco; o_vco_div inside {4'h2, 4'h4, 4'h8}; endproperty
  a_vco: assert property (p_vco) else $error("vco div");
  property p_pre; o_pre_div >= 6'h02 && o_pre_div <= 6'h21; endproperty
  a_pre: assert property (p_pre) else $error("pre div");
  property p_tun; tk && !i_wb_we && i_wb_adr == 8'h0c
    |=> o_wb_dat[31:6] == 26'h0; endproperty
  a_tun: assert property (p_tun) else $error("tune bits");
  property p_umap; tk && !i_wb_we && i_wb_adr == 8'h14
    |=> o_wb_dat == 32'h0; endproperty
  a_umap: assert property (p_umap) else $error("unmapped");
endmodule // oscp_top_sva
bind oscp_top oscp_top_sva u_sva (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
  .i_clk_en(i_clk_en), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .o_core_div(o_core_div), .o_rc_div(o_rc_div),
  .o_vco_div(o_vco_div), .o_pre_div(o_pre_div), .o_fb_mult(o_fb_mult));

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  reg irq = 1'b0, pll_on = 1'b0, fail = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [15:0] wv;
  reg [31:0] wd = 32'h0, q;
  wire [31:0] rdat;
  wire ack, lkd, cf, tick, sec, pin;
  wire [2:0] cur;
  wire [7:0] core;
  wire [8:0] rcd;
  wire [3:0] vco;
  wire [5:0] pre, trim;
  wire [9:0] fb;
  int mismatches = 0, n_checks = 0, i, vx = 4;
  // 200 MHz reference
  always #2.5 clk = ~clk;
  oscp_osc_model osc (.i_pll_on(pll_on), .i_fail(fail),
    .o_pll_locked(lkd), .o_clk_fail(cf), .o_tick(tick));
  oscp_top uut (.i_ref_clk(clk), .i_nrst(nrst), .i_clk_en(1'b1),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'h3), .i_wb_dat(wd), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_cfg_src(3'h2), .i_cfg_monitor(2'h1), .i_pll_locked(lkd),
    .i_clk_fail(cf), .i_new_clk_tick(tick), .i_irq(irq), .o_cur_src(cur),
    .o_sec_osc_en(sec), .o_pin_lock(pin), .o_core_div(core),
    .o_rc_div(rcd), .o_vco_div(vco), .o_pre_div(pre), .o_fb_mult(fb),
    .o_rc_trim(trim));
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one classic cycle; ack seen mid-cycle marks the edge that ends it
  task wb(input [7:0] a, input [15:0] d, input w);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= {16'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task rd_chk(input [7:0] a, input [31:0] e);
    wb(a, 16'h0, 1'b0);
    chk(q, e);
  endtask
  // control writes need the two keys each time
  task ctl(input [15:0] d);
    wb(8'h10, 16'h0046, 1'b1);
    wb(8'h10, 16'h0057, 1'b1);
    wb(8'h00, d, 1'b1);
  endtask
  // poll until the switch request bit drops
  task sw_wait;
    repeat (100)
    begin
      wb(8'h00, 16'h0, 1'b0);
      if (q[0] === 1'b0)
        break;
    end
  endtask
  // sel high pulses the interrupt, low the clock failure
  task pulse(input sel);
    if (sel)
      irq <= 1'b1;
    else
      fail <= 1'b1;
    repeat (4) @(posedge clk);
    irq <= 1'b0;
    fail <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    #100000;
    mismatches++;
    close_out;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(8'h00, 32'h2200);
    rd_chk(8'h04, 32'h3040);
    rd_chk(8'h08, 32'h0030);
    rd_chk(8'h0c, 32'h0000);
    wb(8'h00, 16'h0101, 1'b1);
    rd_chk(8'h00, 32'h2200);
    ctl(16'h0001);
    chk(cur, 3'h2);
    sw_wait;
    rd_chk(8'h00, 32'h0000);
    chk(cur, 3'h0);
    ctl(16'h0001);
    rd_chk(8'h00, 32'h0000);
    ctl(16'h0280);
    ctl(16'h0281);
    repeat (100) @(posedge clk);
    chk(cur, 3'h0);
    ctl(16'h0201);
    sw_wait;
    chk(cur, 3'h2);
    ctl(16'h0301);
    repeat (100) @(posedge clk);
    chk(cur, 3'h2);
    pll_on <= 1'b1;
    sw_wait;
    rd_chk(8'h00, 32'h3320);
    pulse(1'b0);
    rd_chk(8'h00, 32'h3328);
    ctl(16'h334a);
    rd_chk(8'h00, 32'h336a);
    chk({pin, sec}, 2'h3);
    ctl(16'h3300);
    rd_chk(8'h00, 32'h3320);
    chk({pin, sec}, 2'h0);
    pll_on <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(8'h00, 32'h3300);
    for (i = 0; i < 8; i++)
    begin
      wv = {1'b0, i[2:0], 1'b1, i[2:0], i[1:0], 1'b1, i[2:0], 2'h3};
      wb(8'h04, wv, 1'b1);
      rd_chk(8'h04, wv & 16'hffdf);
      chk(core, 8'h01 << i);
      chk(rcd, (i == 7) ? 9'h100 : 9'h001 << i);
      vx = (i[1:0] == 3) ? 8 : (i[1:0] == 2) ? vx : 2 << i[1:0];
      chk(vco, vx);
      chk(pre, i * 4 + 5);
    end
    wb(8'h04, 16'h8800, 1'b1);
    pulse(1'b1);
    rd_chk(8'h04, 32'h8000);
    wb(8'h04, 16'h0800, 1'b1);
    pulse(1'b1);
    rd_chk(8'h04, 32'h0800);
    wb(8'h08, 16'hffff, 1'b1);
    rd_chk(8'h08, 32'h01ff);
    chk(fb, 10'd513);
    wb(8'h0c, 16'hffe0, 1'b1);
    rd_chk(8'h0c, 32'h0020);
    chk(trim, 6'h20);
    wb(8'h14, 16'hffff, 1'b1);
    rd_chk(8'h14, 32'h0);
    close_out;
  end
endmodule // testbench
